//--- bench/rsr_assertions.sv
`timescale 1ns/100ps
module rsr_assertions
  import rsr_pkg::*;
(
  input wire logic       clk_sys,      // clock
  input wire logic       nrst,         // reset
  input wire logic       cmd_valid,    // cmd offered
  input wire rsr_pkg::rsr_cmd_t cmd_code, // cmd code
  input wire logic       cmd_ready,    // cmd ready
  input wire logic       resp_valid,   // resp valid
  input wire logic       meas_start,   // meas pulse
  input wire logic       test_start,   // test pulse
  input wire logic       inst_reset,   // reset pulse
  input wire logic       ev_cmd_err,   // cmd error
  input wire logic       oper_summary, // op summary
  input wire logic [7:0] status_byte,  // status
  input wire logic       srq,          // request
  input wire logic [7:0] event_flags   // flags
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire tk     = cmd_valid && cmd_ready;
  wire trg_tk = tk && cmd_code == RSR_CMD_TRG;
  a_sby_low_zero: assert property (status_byte[3:0] == 4'h0)
    else $error("low nibble set");
  a_srq_tracks: assert property (srq == status_byte[SBY_RQS])
    else $error("srq mismatch");
  a_oss_follows: assert property (##1 status_byte[SBY_OSS] == $past(oper_summary))
    else $error("bit7 stale");
  a_rst_pulse: assert property (tk && cmd_code == RSR_CMD_RST |=> inst_reset)
    else $error("no reset pulse");
  a_trg_cause: assert property (meas_start |-> $past(trg_tk))
    else $error("stray start");
  a_tst_start: assert property (tk && cmd_code == RSR_CMD_TST_Q |=> test_start && !cmd_ready)
    else $error("no test");
  a_cls_clear: assert property (tk && cmd_code == RSR_CMD_CLS |=> !event_flags[EVF_PON])
    else $error("cls kept");
  a_evf_reply: assert property (tk && cmd_code == RSR_CMD_EVF_Q |=> !cmd_ready ##[1:40] resp_valid)
    else $error("no reply");
  a_cmd_err_set: assert property (ev_cmd_err |=> event_flags[EVF_CME])
    else $error("cmd err lost");
  a_mav_hold: assert property (resp_valid && $past(resp_valid) |-> status_byte[SBY_MAV])
    else $error("mav low");
endmodule : rsr_assertions
bind rsr_top rsr_assertions rsr_assertions_inst (.clk_sys, .nrst, .cmd_valid, .cmd_code, .cmd_ready, .resp_valid,
  .meas_start, .test_start, .inst_reset, .ev_cmd_err, .oper_summary, .status_byte, .srq, .event_flags);

//--- bench/rsr_meas_model.sv
`timescale 1ns/100ps
module rsr_meas_model (
  input wire logic        clk_sys,     // clock
  input wire logic        meas_start,  // start meas
  input wire logic        test_start,  // start test
  input wire logic [7:0]  lat,         // latency
  input wire logic [15:0] res_val,     // meas value
  input wire logic [15:0] err_val,     // test sum
  output logic            meas_done,   // meas done
  output logic [15:0]     meas_result, // meas value
  output logic            test_done,   // test done
  output logic [15:0]     test_errsum  // test sum
);
  logic [7:0] cnt = 8'h00;
  logic       tsel = 1'b0;
  initial meas_done = 1'b0;
  initial test_done = 1'b0;
  // Values outside the done pulse are inverted so stale data never matches
  assign meas_result = meas_done ? res_val : ~res_val;
  assign test_errsum = test_done ? err_val : ~err_val;
  always @(posedge clk_sys) begin
    meas_done <= 1'b0;
    test_done <= 1'b0;
    if (meas_start || test_start) begin
      cnt  <= lat;
      tsel <= test_start;
    end else if (cnt != 8'h00) begin
      cnt       <= cnt - 8'h01;
      meas_done <= (cnt == 8'h01) && !tsel;
      test_done <= (cnt == 8'h01) && tsel;
    end
  end
endmodule : rsr_meas_model

//--- bench/rsr_top_tb.sv
`timescale 1ns/100ps
module rsr_top_tb;
  import rsr_pkg::*;
  logic       clk_sys = 0, nrst = 0, cmd_valid = 0, resp_ready = 0, oper_summary = 0;
  logic       cmd_ready, resp_valid, resp_end, meas_start, meas_done, test_start, test_done, inst_reset, srq;
  rsr_cmd_t   cmd_code = RSR_CMD_RST;
  logic [7:0] cmd_arg = 8'h00, resp_data, status_byte, event_flags;
  logic [5:0] ev = 6'h00;
  logic [15:0] meas_result, test_errsum, num, res_val = 16'h3039, err_val = 16'h0000;
  int         err_total = 0, n_compared = 0;
  rsr_top rsr_top_inst (.clk_sys, .nrst, .cmd_valid, .cmd_code, .cmd_arg, .cmd_ready, .resp_data, .resp_valid,
    .resp_end, .resp_ready, .meas_start, .meas_done, .meas_result, .test_start, .test_done, .test_errsum,
    .inst_reset, .ev_user_req(ev[5]), .ev_cmd_err(ev[4]), .ev_exec_err(ev[3]), .ev_dev_err(ev[2]),
    .ev_query_err(ev[1]), .ev_req_ctrl(ev[0]), .oper_summary, .status_byte, .srq, .event_flags);
  rsr_meas_model rsr_meas_model_inst (.clk_sys, .meas_start, .test_start, .lat(8'h14), .res_val, .err_val,
    .meas_done, .meas_result, .test_done, .test_errsum);
  initial forever #2 clk_sys = ~clk_sys;
  task give_verdict;
    if (err_total == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task send(input rsr_cmd_t c, input logic [7:0] a);
    int i;
    for (i = 0; i == 0 || cmd_ready !== 1'b1; i++) begin
      if (i > 300) begin
        err_total++;
        give_verdict();
      end
      @(negedge clk_sys);
    end
    cmd_valid = 1;
    cmd_code = c;
    cmd_arg = a;
    @(negedge clk_sys);
    cmd_valid = 0;
  endtask : send
  task get_num(output logic [15:0] v);
    int i;
    logic [7:0] b;
    logic e;
    v = 0;
    e = 0;
    for (i = 0; !e; i++) begin
      @(negedge clk_sys);
      if (i > 400) begin
        err_total++;
        give_verdict();
      end
      if (resp_valid === 1'b1) begin
        b = resp_data;
        e = resp_end;
        resp_ready = 1;
        @(negedge clk_sys);
        resp_ready = 0;
        if (!e) v = v * 16'd10 + 16'(b - RSR_ASCII_ZERO);
      end
    end
    chk(16'(b), 16'(RSR_ASCII_NL));
  endtask : get_num
  task query(input rsr_cmd_t c, input logic [15:0] exp);
    send(c, 8'h00);
    get_num(num);
    chk(num, exp);
  endtask : query
  initial begin
    repeat (6) @(negedge clk_sys);
    nrst = 1;
    query(RSR_CMD_EVF_Q, 16'd128);
    send(RSR_CMD_EVM_W, 8'h81);
    query(RSR_CMD_EVM_Q, 16'd129);
    chk(16'(status_byte[SBY_ESB]), 16'h0001);
    send(RSR_CMD_SRM_W, 8'hA0);
    query(RSR_CMD_SRM_Q, 16'd160);
    chk(16'(srq), 16'h0001);
    send(RSR_CMD_SBY_Q, 8'h00);
    chk(16'(status_byte[SBY_MAV]), 16'h0001);
    get_num(num);
    chk(num, 16'd96);
    // Status byte lags the last byte taken by one cycle
    @(negedge clk_sys);
    chk(16'(status_byte), 16'h0060);
    oper_summary = 1;
    repeat (2) @(negedge clk_sys);
    chk(16'(status_byte), 16'h00E0);
    oper_summary = 0;
    ev = 6'h3F;
    @(negedge clk_sys);
    ev = 6'h00;
    query(RSR_CMD_EVF_Q, 16'd254);
    send(RSR_CMD_CLS, 8'h00);
    repeat (2) @(negedge clk_sys);
    chk({event_flags, status_byte}, 16'h0000);
    send(rsr_cmd_t'(4'hF), 8'h00);
    repeat (2) @(negedge clk_sys);
    chk(16'(event_flags), 16'h0020);
    query(RSR_CMD_IDN_Q, RSR_IDENT_CODE);
    send(RSR_CMD_CLS, 8'h00);
    send(RSR_CMD_TRG, 8'h00);
    get_num(num);
    chk(num, 16'd12345);
    send(RSR_CMD_TRG, 8'h00);
    send(RSR_CMD_OPC_W, 8'h00);
    send(RSR_CMD_TRG, 8'h00);
    chk(16'(event_flags), 16'h0010);
    get_num(num);
    chk(num, 16'd12345);
    chk(16'(event_flags), 16'h0011);
    res_val = 16'd2;
    send(RSR_CMD_TRG, 8'h00);
    send(RSR_CMD_OPC_Q, 8'h00);
    get_num(num);
    chk(num, 16'd2);
    get_num(num);
    chk(num, 16'd1);
    query(RSR_CMD_TST_Q, 16'd0);
    err_val = 16'd7;
    query(RSR_CMD_TST_Q, 16'd7);
    send(RSR_CMD_TRG, 8'h00);
    send(RSR_CMD_RST, 8'h00);
    // Aborted measurement must never produce a response
    repeat (30) @(negedge clk_sys);
    chk(16'(resp_valid), 16'h0000);
    query(RSR_CMD_EVM_Q, 16'd129);
    give_verdict();
  end
endmodule : rsr_top_tb

//--- hw/rsr_fmt.sv
`timescale 1ns/100ps
module rsr_fmt (
  input  wire logic clk_sys,  // System clock
  input  wire logic nrst,     // Async reset, active low
  rsr_fmt_if.fmt    fi        // Formatter side
);
  import rsr_pkg::*;

  typedef enum {F_IDLE, F_DIV, F_OUT, F_NL} rsr_fst_t;
  typedef struct packed {
    rsr_fst_t             st;
    logic [15:0]          val;
    logic [RSR_IDX_W-1:0] idx;
    logic [3:0]           dig;
    logic                 seen;
    logic [7:0]           data;
    logic                 valid;
    logic                 last;
    logic                 busy;
  } rsr_fmt_t;

  localparam logic [RSR_IDX_W-1:0] LAST_IDX = RSR_IDX_W'(RSR_DIGITS - 1);

  function automatic logic [15:0] rsr_div(input logic [RSR_IDX_W-1:0] i);
    case (i)
      3'h0:    rsr_div = 16'h2710;
      3'h1:    rsr_div = 16'h03E8;
      3'h2:    rsr_div = 16'h0064;
      3'h3:    rsr_div = 16'h000A;
      default: rsr_div = 16'h0001;
    endcase
  endfunction : rsr_div

  rsr_fmt_t s, n;

  always_comb begin
    n = s;
    case (s.st)
      F_IDLE: begin
        if (fi.start) begin
          n.st   = F_DIV;
          n.val  = fi.value;
          n.idx  = '0;
          n.dig  = '0;
          n.seen = 1'b0;
          n.busy = 1'b1;
        end
      end
      F_DIV: begin
        // Digit by repeated subtraction, leading zeros suppressed
        if (s.val >= rsr_div(s.idx)) begin
          n.val = s.val - rsr_div(s.idx);
          n.dig = s.dig + 4'h1;
        end else if (s.dig != 4'h0 || s.seen || s.idx == LAST_IDX) begin
          n.data  = RSR_ASCII_ZERO + {4'h0, s.dig};
          n.valid = 1'b1;
          n.last  = 1'b0;
          n.seen  = 1'b1;
          n.st    = F_OUT;
        end else begin
          n.idx = s.idx + 1'b1;
        end
      end
      F_OUT: begin
        if (fi.ready) begin
          n.valid = 1'b0;
          n.dig   = '0;
          if (s.idx == LAST_IDX) begin
            n.data  = RSR_ASCII_NL;  // see [RULE9]
            n.last  = 1'b1;
            n.valid = 1'b1;
            n.st    = F_NL;
          end else begin
            n.idx = s.idx + 1'b1;
            n.st  = F_DIV;
          end
        end
      end
      F_NL: begin
        if (fi.ready) begin
          n.valid = 1'b0;
          n.last  = 1'b0;
          n.busy  = 1'b0;  // see [RULE14]
          n.st    = F_IDLE;
        end
      end
      default: n.st = F_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s <= '{st: F_IDLE, default: '0};
    end else begin
      s <= n;
    end
  end

  assign fi.busy  = s.busy;
  assign fi.data  = s.data;
  assign fi.valid = s.valid;
  assign fi.last  = s.last;
endmodule : rsr_fmt

//--- hw/rsr_fmt_if.sv
`timescale 1ns/100ps
interface rsr_fmt_if;
  logic        start;
  logic [15:0] value;
  logic        busy;
  logic [7:0]  data;
  logic        valid;
  logic        last;
  logic        ready;
  modport ctrl (output start, output value, output ready, input busy, input data, input valid, input last);
  modport fmt  (input start, input value, input ready, output busy, output data, output valid, output last);
endinterface : rsr_fmt_if

//--- hw/rsr_pkg.sv
// Functional notes
// [RULE1] Reset command returns instrument to reset state
// [RULE2] Trigger starts one measurement, result to output
// [RULE3] Clear-status zeroes event flags and status summary
// [RULE4] Self-test query returns summed error codes
// [RULE5] Event enable mask set and queried decimally
// [RULE6] Event flag bit layout, power-on down to complete
// [RULE7] Service request mask set and queried decimally
// [RULE8] Status byte layout, low nibble always zero
// [RULE9] Event query returns flags, newline with end
// [RULE10] Status byte query leaves status byte unchanged
// [RULE11] Operation complete flag set after measurements finish
// [RULE12] Completion query waits, then returns character one
// [RULE13] Summary and request service from enabled bits
// [RULE14] Message available while response bytes remain unread
package rsr_pkg;
  localparam int          RSR_VAL_W      = 16;
  localparam int          RSR_DIGITS     = 5;
  localparam int          RSR_IDX_W      = 3;
  localparam logic [7:0]  RSR_EVF_RESET  = 8'h80;
  localparam logic [7:0]  RSR_MASK_RESET = 8'h00;
  localparam int          EVF_PON        = 7;
  localparam int          EVF_URQ        = 6;
  localparam int          EVF_CME        = 5;
  localparam int          EVF_EXE        = 4;
  localparam int          EVF_DDE        = 3;
  localparam int          EVF_QYE        = 2;
  localparam int          EVF_RQC        = 1;
  localparam int          EVF_OPC        = 0;
  localparam int          SBY_OSS        = 7;
  localparam int          SBY_RQS        = 6;
  localparam int          SBY_ESB        = 5;
  localparam int          SBY_MAV        = 4;
  localparam logic [7:0]  RSR_ASCII_ZERO = 8'h30;
  localparam logic [7:0]  RSR_ASCII_NL   = 8'h0A;
  localparam logic [15:0] RSR_OPC_REPLY  = 16'h0001;
  localparam logic [15:0] RSR_IDENT_CODE = 16'h0001;  // Arbitrary identity value

  typedef enum logic [3:0] {
    RSR_CMD_RST, RSR_CMD_TRG, RSR_CMD_CLS, RSR_CMD_TST_Q, RSR_CMD_IDN_Q,
    RSR_CMD_EVM_W, RSR_CMD_EVM_Q, RSR_CMD_SRM_W, RSR_CMD_SRM_Q,
    RSR_CMD_EVF_Q, RSR_CMD_SBY_Q, RSR_CMD_OPC_W, RSR_CMD_OPC_Q
  } rsr_cmd_t;
endpackage : rsr_pkg

//--- hw/rsr_top.sv
`timescale 1ns/100ps
module rsr_top (
  input  wire logic                     clk_sys,       // System clock
  input  wire logic                     nrst,          // Async reset, active low
  input  wire logic                     cmd_valid,     // Decoded command present
  input  wire rsr_pkg::rsr_cmd_t        cmd_code,      // Command code
  input  wire logic [7:0]               cmd_arg,       // Mask argument
  output logic                          cmd_ready,     // Command accepted when high
  output logic [7:0]                    resp_data,     // Response byte
  output logic                          resp_valid,    // Response byte valid
  output logic                          resp_end,      // Byte carries END
  input  wire logic                     resp_ready,    // Controller reads byte
  output logic                          meas_start,    // Measurement start pulse
  input  wire logic                     meas_done,     // Measurement finished pulse
  input  wire logic [rsr_pkg::RSR_VAL_W-1:0] meas_result, // Measurement value
  output logic                          test_start,    // Self-test start pulse
  input  wire logic                     test_done,     // Self-test finished pulse
  input  wire logic [rsr_pkg::RSR_VAL_W-1:0] test_errsum, // Sum of error codes
  output logic                          inst_reset,    // Instrument reset pulse
  input  wire logic                     ev_user_req,   // User request event
  input  wire logic                     ev_cmd_err,    // Command error event
  input  wire logic                     ev_exec_err,   // Execution error event
  input  wire logic                     ev_dev_err,    // Device error event
  input  wire logic                     ev_query_err,  // Query error event
  input  wire logic                     ev_req_ctrl,   // Request control event
  input  wire logic                     oper_summary,  // Operation status summary
  output logic [7:0]                    status_byte,   // Live status byte
  output logic                          srq,           // Service request
  output logic [7:0]                    event_flags    // Live event flags
);
  import rsr_pkg::*;

  typedef struct packed {
    logic [7:0]           evf;
    logic [7:0]           evm;
    logic [7:0]           srm;
    logic [7:0]           sby;
    logic                 cmd_ready;
    logic                 meas_busy;
    logic                 pend;
    logic [RSR_VAL_W-1:0] pend_val;
    logic                 test_busy;
    logic                 tflag;
    logic [RSR_VAL_W-1:0] tval;
    logic                 opc_armed;
    logic                 opcq_wait;
    logic                 fmt_start;
    logic [RSR_VAL_W-1:0] fmt_value;
    logic                 meas_start;
    logic                 test_start;
    logic                 inst_reset;
  } rsr_state_t;

  rsr_state_t s, n;
  rsr_fmt_if  fi ();
  logic [7:0] ev;
  logic [7:0] stb_low;
  logic       take;
  logic       free;

  rsr_fmt u_fmt (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .fi      (fi.fmt)
  );

  assign fi.start = s.fmt_start;
  assign fi.value = s.fmt_value;
  assign fi.ready = resp_ready;

  always_comb begin
    n            = s;
    n.fmt_start  = 1'b0;
    n.meas_start = 1'b0;
    n.test_start = 1'b0;
    n.inst_reset = 1'b0;
    ev           = '0;
    stb_low      = '0;
    take         = cmd_valid && s.cmd_ready;
    free         = !fi.busy && !s.fmt_start;
    ev[EVF_URQ]  = ev_user_req;  // see [RULE6]
    ev[EVF_CME]  = ev_cmd_err;
    ev[EVF_EXE]  = ev_exec_err;
    ev[EVF_DDE]  = ev_dev_err;
    ev[EVF_QYE]  = ev_query_err;
    ev[EVF_RQC]  = ev_req_ctrl;
    if (s.meas_busy && meas_done) begin
      n.meas_busy = 1'b0;
      n.pend      = 1'b1;  // see [RULE2]
      n.pend_val  = meas_result;
    end
    if (s.test_busy && test_done) begin
      n.tflag = 1'b1;
      n.tval  = test_errsum;  // see [RULE4]
    end
    if (s.opc_armed && !s.meas_busy) begin
      ev[EVF_OPC] = 1'b1;  // see [RULE11]
      n.opc_armed = 1'b0;
    end
    // Formatter owner: queued result first, then self-test, then completion
    if (free) begin
      if (s.pend) begin
        n.fmt_start = 1'b1;
        n.fmt_value = s.pend_val;  // see [RULE2]
        n.pend      = 1'b0;
      end else if (s.tflag) begin
        n.fmt_start = 1'b1;
        n.fmt_value = s.tval;  // see [RULE4]
        n.tflag     = 1'b0;
        n.test_busy = 1'b0;
      end else if (s.opcq_wait && !s.meas_busy) begin
        n.fmt_start = 1'b1;
        n.fmt_value = RSR_OPC_REPLY;  // see [RULE12]
        n.opcq_wait = 1'b0;
      end
    end
    if (take) begin
      case (cmd_code)
        RSR_CMD_RST: begin
          n.inst_reset = 1'b1;  // see [RULE1]
          n.meas_busy  = 1'b0;
          n.pend       = 1'b0;
          n.opc_armed  = 1'b0;
        end
        RSR_CMD_TRG: begin
          if (!s.meas_busy) begin
            n.meas_start = 1'b1;  // see [RULE2]
            n.meas_busy  = 1'b1;
          end else begin
            ev[EVF_EXE] = 1'b1;
          end
        end
        RSR_CMD_CLS: begin
          n.evf       = '0;  // see [RULE3]
          n.opc_armed = 1'b0;
        end
        RSR_CMD_TST_Q: begin
          n.test_start = 1'b1;  // see [RULE4]
          n.test_busy  = 1'b1;
        end
        RSR_CMD_IDN_Q: begin
          n.fmt_start = 1'b1;
          n.fmt_value = RSR_IDENT_CODE;
        end
        RSR_CMD_EVM_W: n.evm = cmd_arg;  // see [RULE5]
        RSR_CMD_EVM_Q: begin
          n.fmt_start = 1'b1;
          n.fmt_value = {8'h00, s.evm};  // see [RULE5]
        end
        RSR_CMD_SRM_W: n.srm = cmd_arg;  // see [RULE7]
        RSR_CMD_SRM_Q: begin
          n.fmt_start = 1'b1;
          n.fmt_value = {8'h00, s.srm};  // see [RULE7]
        end
        RSR_CMD_EVF_Q: begin
          n.fmt_start = 1'b1;
          n.fmt_value = {8'h00, s.evf};  // see [RULE9]
        end
        RSR_CMD_SBY_Q: begin
          n.fmt_start = 1'b1;
          n.fmt_value = {8'h00, s.sby};  // see [RULE10]
        end
        RSR_CMD_OPC_W: n.opc_armed = 1'b1;  // see [RULE11]
        RSR_CMD_OPC_Q: n.opcq_wait = 1'b1;  // see [RULE12]
        default:       ev[EVF_CME] = 1'b1;
      endcase
    end
    // New events win over a clear in the same cycle
    n.evf            = n.evf | ev;  // see [RULE3]
    stb_low[SBY_OSS] = oper_summary;  // see [RULE8]
    stb_low[SBY_ESB] = |(n.evf & n.evm);  // see [RULE13]
    stb_low[SBY_MAV] = fi.busy || s.fmt_start || n.fmt_start;  // see [RULE14]
    n.sby            = stb_low;
    n.sby[SBY_RQS]   = |(stb_low & n.srm);  // see [RULE13]
    n.cmd_ready      = !(n.fmt_start || n.pend || n.test_busy || n.opcq_wait || fi.busy || s.fmt_start);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s     <= '0;
      s.evf <= RSR_EVF_RESET;  // see [RULE6]
      s.evm <= RSR_MASK_RESET;
      s.srm <= RSR_MASK_RESET;
    end else begin
      s <= n;
    end
  end

  assign cmd_ready   = s.cmd_ready;
  assign resp_data   = fi.data;
  assign resp_valid  = fi.valid;
  assign resp_end    = fi.last;
  assign meas_start  = s.meas_start;
  assign test_start  = s.test_start;
  assign inst_reset  = s.inst_reset;
  assign status_byte = s.sby;  // see [RULE8]
  assign srq         = s.sby[SBY_RQS];
  assign event_flags = s.evf;
endmodule : rsr_top
